// ==== pkg/rwc_pkg.sv ====
package rwc_pkg;
    // register map
    localparam logic [7:0] RWC_ADDR_WDOG = 8'hD8;
    localparam logic [7:0] RWC_WDOG_RESET = 8'hFE;
    localparam int RWC_BIT_ACTIVATE = 0;
    localparam int RWC_BIT_SOFT_RESET = 1;
    localparam int RWC_CNT_MSB = 6;
    localparam logic [11:0] RWC_RESET_VECTOR = 12'hFFE;
    // extra control/status register
    localparam logic [7:0] RWC_ADDR_CTRL = 8'hE0;
    localparam int RWC_BIT_RETURN_FROM_INTERRUPT = 0;
    localparam int RWC_BIT_STOP = 1;
    localparam int RWC_BIT_WAKE = 2;
    // prescale of the watchdog: 3072 clocks per period step / 64 = 48 per tick
    localparam int RWC_WDOG_PRESCALE = 48;
    // stabilisation delay in ns and cycles at 20 MHz
    localparam int RWC_CLK_NS = 50;
    localparam int RWC_STAB_NS = 204800;
    localparam int RWC_STAB_CYCLES = (RWC_STAB_NS + RWC_CLK_NS - 1) / RWC_CLK_NS;
    typedef enum logic [1:0] {
        RWC_ST_HOLD = 2'b00,
        RWC_ST_DELAY = 2'b01,
        RWC_ST_INIT = 2'b11,
        RWC_ST_RUN = 2'b10
    } rwc_state_t;
endpackage

// ==== core/rwc_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module rwc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== core/rwc_delay.sv ====
`timescale 1ns/1ns
`default_nettype none
module rwc_delay #(
    parameter int CYCLES = 4096
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // control
    input wire logic i_hold,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] count;
    // any hold restarts the whole delay, so short pulses still give a full delay
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
            o_done <= 1'b0;
        end else if (i_hold) begin
            count <= '0;
            o_done <= 1'b0;
        end else if (!o_done) begin
            if (count == LAST) begin
                o_done <= 1'b1;
            end else begin
                count <= count + CW'(1);
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/rwc_top.sv ====
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - io held pulled-up input, no execution during reset
// - stabilisation delay then initialisation starts
// - watchdog end of count asserts reset, reloads counter
// - watchdog reset restarts like pin reset
// - low voltage holds static reset when enabled
// - internal reset sources drive reset pin low
// - reset clears stack, loads vector 0FFEh
// - reset sets interrupt flag, nmi mode
// - return from interrupt restores normal mode
// - unreloaded watchdog counts to zero, resets
// - software option: disabled until activate bit
// - activated watchdog cannot be disabled
// - disabled watchdog allows true stop
// - hardware option: always on, stop acts wait
// - external stop: nmi low wait, high stop
// - wake from stop resumes frozen count
// - reset held while pin low, then delay
// - clearing soft reset bit triggers reset
module rwc_top
    import rwc_pkg::*;
#(
    parameter int STAB_CYCLES = RWC_STAB_CYCLES,
    parameter int PRESCALE = RWC_WDOG_PRESCALE
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // options
    input wire logic i_opt_hw_wdog,
    input wire logic i_opt_ext_stop,
    input wire logic i_opt_lvd_en,
    // pins and detectors
    input wire logic i_reset_pin_n,
    input wire logic i_por,
    input wire logic i_low_voltage_detect,
    input wire logic i_nmi_pin,
    // core events
    input wire logic i_stop_req,
    input wire logic i_wake,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // reset pin drive (open drain)
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    // core control
    output logic o_core_reset,
    output logic o_io_safe,
    output logic o_stack_clear,
    output logic [11:0] o_pc_load,
    output logic o_pc_load_en,
    output logic o_nmi_mode,
    output logic o_stop_clk,
    output logic o_wait_mode
);
    //////////////////////////////////////////////////////////////////////
    logic [2:0] pins_sync;
    logic pin_low;
    logic por_s;
    logic lvd_s;
    logic nmi_s;
    logic wdog_fire;
    logic soft_fire;
    logic internal_src;
    logic any_src;
    logic delay_done;
    logic [7:0] wdog_reg;
    logic frozen;
    localparam int PW = $clog2(PRESCALE);
    localparam logic [PW-1:0] PRESC_LAST = PW'(PRESCALE - 1);
    logic [PW-1:0] presc;
    rwc_state_t state;
    rwc_state_t next_state;

    rwc_sync #(.WIDTH(3), .RESET_VAL(3'h7)) u_sync_hi (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_async({i_reset_pin_n, i_por, i_nmi_pin}),
        .o_sync(pins_sync)
    );
    rwc_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_sync_lvd (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_async(i_low_voltage_detect),
        .o_sync(lvd_s)
    );
    assign pin_low = !pins_sync[2];
    assign por_s = pins_sync[1];
    assign nmi_s = pins_sync[0];

    //////////////////////////////////////////////////////////////////////
    // physical counter: T0..T5 reversed into bits 7..2, SR is bit 6 of count
    function automatic logic [6:0] wd_count(input logic [7:0] r);
        wd_count = {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
    endfunction
    function automatic logic [7:0] wd_reg(input logic [6:0] c, input logic act);
        wd_reg = {c[0], c[1], c[2], c[3], c[4], c[5], c[6], act};
    endfunction

    logic wd_active;
    logic stop_real;
    logic [6:0] cnt;
    assign wd_active = wdog_reg[RWC_BIT_ACTIVATE] | i_opt_hw_wdog;
    // stop becomes true stop only when watchdog off, or ext control with nmi high
    assign stop_real = !wd_active || (i_opt_ext_stop && nmi_s);
    assign cnt = wd_count(wdog_reg);
    assign soft_fire = i_wr && (i_addr == RWC_ADDR_WDOG) && !i_wdata[RWC_BIT_SOFT_RESET] && state == RWC_ST_RUN;
    assign wdog_fire = wd_active && !frozen && state == RWC_ST_RUN && presc == '0
        && cnt[RWC_CNT_MSB] && cnt[RWC_CNT_MSB-1:0] == '0;
    assign internal_src = por_s || (i_opt_lvd_en && lvd_s) || wdog_fire || soft_fire;
    assign any_src = internal_src || pin_low;

    //////////////////////////////////////////////////////////////////////
    // watchdog register; reset of any source reinitialises it
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wdog_reg <= RWC_WDOG_RESET;
            presc <= '0;
        end else if (state != RWC_ST_RUN || any_src) begin
            wdog_reg <= RWC_WDOG_RESET;
            presc <= '0;
        end else if (i_wr && i_addr == RWC_ADDR_WDOG) begin
            // activate bit is sticky once set
            wdog_reg <= {i_wdata[7:1], i_wdata[0] | wdog_reg[RWC_BIT_ACTIVATE]};
            presc <= '0;
        end else if (!frozen) begin
            if (presc == PRESC_LAST) begin
                presc <= '0;
            end else begin
                presc <= presc + 1'b1;
            end
            if (presc == '0) begin
                wdog_reg <= wd_reg(cnt - 7'h01, wdog_reg[RWC_BIT_ACTIVATE]);
            end
        end
    end

    // a true stop with the watchdog active freezes counting until an interrupt wakes the core
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            frozen <= 1'b0;
            o_stop_clk <= 1'b0;
            o_wait_mode <= 1'b0;
        end else if (state != RWC_ST_RUN || any_src || i_wake) begin
            frozen <= 1'b0;
            o_stop_clk <= 1'b0;
            o_wait_mode <= 1'b0;
        end else if (i_stop_req) begin
            frozen <= stop_real && wd_active;
            o_stop_clk <= stop_real;
            o_wait_mode <= !stop_real;
        end
    end

    //////////////////////////////////////////////////////////////////////
    rwc_delay #(.CYCLES(STAB_CYCLES)) u_delay (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_hold(any_src || state == RWC_ST_HOLD),
        .o_done(delay_done)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            RWC_ST_HOLD: begin
                next_state = any_src ? RWC_ST_HOLD : RWC_ST_DELAY;
            end
            RWC_ST_DELAY: begin
                if (any_src) begin
                    next_state = RWC_ST_HOLD;
                end else if (delay_done) begin
                    next_state = RWC_ST_INIT;
                end
            end
            RWC_ST_INIT: begin
                next_state = any_src ? RWC_ST_HOLD : RWC_ST_RUN;
            end
            RWC_ST_RUN: begin
                next_state = any_src ? RWC_ST_HOLD : RWC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= RWC_ST_HOLD;
        end else begin
            state <= next_state;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // reset outputs and pin drive
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_core_reset <= 1'b1;
            o_io_safe <= 1'b1;
            o_reset_pin_o <= 1'b0;
            o_reset_pin_oe <= 1'b0;
        end else begin
            o_core_reset <= next_state != RWC_ST_RUN;
            o_io_safe <= next_state != RWC_ST_RUN;
            o_reset_pin_o <= 1'b0;
            // wired-and pin: only internal sources pull it; no self-hold, since the
            // synchronised pin would see our own pull and keep the reset forever
            o_reset_pin_oe <= internal_src;
        end
    end

    // initialisation: clear stack, load vector, enter nmi mode
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_stack_clear <= 1'b0;
            o_pc_load <= '0;
            o_pc_load_en <= 1'b0;
            o_nmi_mode <= 1'b1;
        end else begin
            o_stack_clear <= next_state == RWC_ST_INIT;
            o_pc_load_en <= next_state == RWC_ST_INIT;
            o_pc_load <= RWC_RESET_VECTOR;
            if (next_state != RWC_ST_RUN) begin
                o_nmi_mode <= 1'b1;
            end else if (i_wr && i_addr == RWC_ADDR_CTRL && i_wdata[RWC_BIT_RETURN_FROM_INTERRUPT]) begin
                o_nmi_mode <= 1'b0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                RWC_ADDR_WDOG: o_rdata <= {wdog_reg[7:1], wd_active};
                RWC_ADDR_CTRL: o_rdata <= {5'h00, frozen, o_stop_clk, o_nmi_mode};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);

    sequence s_reset_release;
        !o_core_reset ##0 $past(o_core_reset);
    endsequence

    // stop request that the stop logic acts on in this cycle
    sequence s_stop_taken;
        state == RWC_ST_RUN && !any_src && !i_wake && i_stop_req;
    endsequence

    // counting tick with no reload and no reset pending
    sequence s_count_tick;
        state == RWC_ST_RUN && !any_src && !frozen && presc == '0 && !(i_wr && i_addr == RWC_ADDR_WDOG);
    endsequence

    // interrupt arrives while the counter is frozen
    sequence s_wake_frozen;
        frozen && i_wake && state == RWC_ST_RUN && !any_src;
    endsequence

    a_pin_holds_reset: assert property (pin_low |=> o_core_reset) else $error("reset not held");
    a_safe_io_reset: assert property (o_core_reset |-> o_io_safe) else $error("io not safe");
    a_internal_pin: assert property (internal_src |=> o_reset_pin_oe && !o_reset_pin_o)
        else $error("pin not pulled");
    a_vector_load: assert property (o_pc_load_en |-> o_pc_load == 12'hFFE && o_stack_clear)
        else $error("bad vector");
    a_nmi_after: assert property (s_reset_release |-> o_nmi_mode) else $error("nmi flag clear");
    a_init_delay: assert property (s_reset_release |-> $past(o_pc_load_en)) else $error("no init");
    a_lvd_static: assert property (i_opt_lvd_en && lvd_s |=> o_core_reset) else $error("lvd ignored");
    a_wdog_sticky: assert property (state == RWC_ST_RUN && wdog_reg[0] && !any_src |=> wdog_reg[0])
        else $error("wdog disabled");
    a_hw_no_stop: assert property (i_opt_hw_wdog && !i_opt_ext_stop |-> !o_stop_clk)
        else $error("stop in hw");
    a_soft_reset: assert property (soft_fire |=> o_core_reset) else $error("no soft reset");
    a_true_stop: assert property (s_stop_taken ##0 (!wd_active) |=> o_stop_clk && !o_wait_mode)
        else $error("no true stop");
    a_stop_as_wait: assert property (
        s_stop_taken ##0 (i_opt_hw_wdog && !i_opt_ext_stop) |=> o_wait_mode && !o_stop_clk)
        else $error("stop not taken as wait");
    a_ext_nmi_low: assert property (
        s_stop_taken ##0 (i_opt_ext_stop && wd_active && !nmi_s) |=> o_wait_mode && !frozen)
        else $error("stop not wait on nmi low");
    a_ext_nmi_high: assert property (
        s_stop_taken ##0 (i_opt_ext_stop && wd_active && nmi_s) |=> frozen && o_stop_clk)
        else $error("no freeze on nmi high");
    a_frozen_hold: assert property (
        frozen && state == RWC_ST_RUN && !any_src && !(i_wr && i_addr == RWC_ADDR_WDOG) |=> $stable(wdog_reg))
        else $error("frozen counter moved");
    a_wake_resume: assert property (s_wake_frozen |=> !frozen) else $error("no resume on wake");
    a_count_down: assert property (s_count_tick |=> cnt == $past(cnt) - 7'h01)
        else $error("counter not decremented");
    a_wdog_reinit: assert property (wdog_fire |=> wdog_reg == RWC_WDOG_RESET && state == RWC_ST_HOLD)
        else $error("watchdog not reinitialised");
    a_return_from_interrupt_normal: assert property (
        state == RWC_ST_RUN && !any_src && i_wr && i_addr == RWC_ADDR_CTRL && i_wdata[RWC_BIT_RETURN_FROM_INTERRUPT] |=> !o_nmi_mode)
        else $error("nmi mode kept");
    a_sources_hold: assert property (any_src |=> state == RWC_ST_HOLD) else $error("source ignored");
endmodule
`default_nettype wire

// ==== testbench/rwc_pin_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// reset pin wire: pull-up, wired-and of board switch and device drive
module rwc_pin_model (
    // drivers
    input wire logic i_ext_low,
    input wire logic i_dev_oe,
    input wire logic i_dev_o,
    // wire level
    output logic o_pin_n
);
    // released wire returns to the pull-up level, never a stale value
    assign o_pin_n = (i_ext_low || (i_dev_oe && !i_dev_o)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ==== testbench/rwc_top_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module rwc_top_bench;
    import rwc_pkg::*;
    logic i_clk_sys, i_arst_n, i_opt_hw_wdog, i_opt_ext_stop, i_opt_lvd_en, i_reset_pin_n, i_por;
    logic i_low_voltage_detect, i_nmi_pin, i_stop_req, i_wake, i_wr, i_rd, ext_low, rd_seen;
    logic o_reset_pin_o, o_reset_pin_oe, o_core_reset, o_io_safe, o_stack_clear, o_pc_load_en;
    logic o_nmi_mode, o_stop_clk, o_wait_mode;
    logic [7:0] i_addr, i_wdata, o_rdata, ra;
    logic [11:0] o_pc_load;
    logic [7:0] exp_q[$];
    int fail_count, check_count, saw_init;
    // short counts keep the run brief
    rwc_top #(.STAB_CYCLES(8), .PRESCALE(2)) rwc_top_i (
        .i_clk_sys(i_clk_sys),
        .i_arst_n(i_arst_n),
        .i_opt_hw_wdog(i_opt_hw_wdog),
        .i_opt_ext_stop(i_opt_ext_stop),
        .i_opt_lvd_en(i_opt_lvd_en),
        .i_reset_pin_n(i_reset_pin_n),
        .i_por(i_por),
        .i_low_voltage_detect(i_low_voltage_detect),
        .i_nmi_pin(i_nmi_pin),
        .i_stop_req(i_stop_req),
        .i_wake(i_wake),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .o_reset_pin_o(o_reset_pin_o),
        .o_reset_pin_oe(o_reset_pin_oe),
        .o_core_reset(o_core_reset),
        .o_io_safe(o_io_safe),
        .o_stack_clear(o_stack_clear),
        .o_pc_load(o_pc_load),
        .o_pc_load_en(o_pc_load_en),
        .o_nmi_mode(o_nmi_mode),
        .o_stop_clk(o_stop_clk),
        .o_wait_mode(o_wait_mode)
    );
    rwc_pin_model rwc_pin_model_i (.i_ext_low(ext_low), .i_dev_oe(o_reset_pin_oe),
        .i_dev_o(o_reset_pin_o), .o_pin_n(i_reset_pin_n));
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    ////////////////////////////////////////////////////////////////
    task final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // read data are only valid in the cycle after the strobe
    always @(posedge i_clk_sys) rd_seen <= i_rd;
    always @(negedge i_clk_sys) begin
        if (rd_seen && exp_q.size() > 0) begin
            chk("rdata", {4'h0, exp_q.pop_front()}, {4'h0, o_rdata});
        end
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(negedge i_clk_sys);
    endtask
    task ev(input logic s);
        @(posedge i_clk_sys);
        i_stop_req <= s;
        i_wake <= !s;
        @(posedge i_clk_sys);
        {i_stop_req, i_wake} <= 2'b00;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    task wait_core(input logic lvl, input int lim);
        int n;
        n = 0;
        while (o_core_reset !== lvl && n < lim) begin
            @(negedge i_clk_sys);
            if (o_pc_load_en === 1'b1) begin
                saw_init++;
                chk("pc_load", 12'hFFE, o_pc_load);
                chk("stack_clear", 1, o_stack_clear);
            end
            n++;
        end
        if (o_core_reset !== lvl) begin
            fail_count++;
            final_report();
        end
    endtask
    task run_up();
        saw_init = 0;
        wait_core(1'b0, 300);
        chk("init_seen", 1, saw_init);
        chk("io_safe", 0, o_io_safe);
        chk("nmi_mode", 1, o_nmi_mode);
    endtask
    task in_reset(input logic oe, input int lim);
        wait_core(1'b1, lim);
        chk("io_safe", 1, o_io_safe);
        chk("pin_oe", oe, o_reset_pin_oe);
        chk("pin_o", 0, o_reset_pin_o);
    endtask
    task restart(input logic hw, input logic ext);
        i_arst_n <= 1'b0;
        i_opt_hw_wdog <= hw;
        i_opt_ext_stop <= ext;
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        // the counter runs as a timer in the run state, so its reset value is read while still in reset
        rd(RWC_ADDR_WDOG, {RWC_WDOG_RESET[7:1], hw});
        run_up();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {i_arst_n, i_opt_hw_wdog, i_opt_ext_stop, i_opt_lvd_en, i_por, i_low_voltage_detect} = '0;
        {i_nmi_pin, i_stop_req, i_wake, i_wr, i_rd, ext_low} = '0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        fail_count = 0;
        check_count = 0;
        void'($urandom(97));
        restart(1'b0, 1'b0);
        repeat (4) begin
            ra = 8'($urandom);
            if (ra != RWC_ADDR_WDOG && ra != RWC_ADDR_CTRL) rd(ra, 8'h00);
        end
        rd(RWC_ADDR_CTRL, 8'h01);
        wr(RWC_ADDR_CTRL, 8'h01);
        rd(RWC_ADDR_CTRL, 8'h00);
        ev(1'b1);
        chk("stop_clk", 1, o_stop_clk);
        chk("wait_mode", 0, o_wait_mode);
        ev(1'b0);
        // a disabled watchdog only runs as a timer
        repeat (200) @(negedge i_clk_sys);
        chk("core_reset", 0, o_core_reset);
        wr(RWC_ADDR_WDOG, 8'hFF);
        wr(RWC_ADDR_WDOG, 8'h82);
        in_reset(1'b1, 20);
        rd(RWC_ADDR_WDOG, RWC_WDOG_RESET);
        run_up();
        wr(RWC_ADDR_WDOG, 8'hFC);
        in_reset(1'b1, 10);
        run_up();
        for (int k = 0; k < 3; k++) begin
            i_opt_lvd_en <= 1'b1;
            {i_low_voltage_detect, i_por, ext_low} <= 3'b001 << k;
            in_reset(k != 0, 10);
            repeat (30) @(negedge i_clk_sys);
            chk("core_reset", 1, o_core_reset);
            {i_low_voltage_detect, i_por, ext_low} <= 3'b000;
            run_up();
        end
        restart(1'b1, 1'b0);
        ev(1'b1);
        chk("wait_mode", 1, o_wait_mode);
        chk("stop_clk", 0, o_stop_clk);
        in_reset(1'b1, 300);
        restart(1'b1, 1'b1);
        ev(1'b1);
        chk("wait_mode", 1, o_wait_mode);
        ev(1'b0);
        i_nmi_pin <= 1'b1;
        wr(RWC_ADDR_WDOG, 8'hC3);
        ev(1'b1);
        chk("stop_clk", 1, o_stop_clk);
        repeat (60) @(negedge i_clk_sys);
        chk("core_reset", 0, o_core_reset);
        ev(1'b0);
        in_reset(1'b1, 30);
        run_up();
        final_report();
    end
endmodule
`default_nettype wire
